// file: bzs_pkg.sv
// shared constants, register map and helpers for the bus zone selection logic
package bzs_pkg;
	// sizes
	localparam int NUM_TERM = 7;
	localparam int NUM_ZONE = 6;
	localparam int NUM_CHECK = 3;
	localparam int CUR_W = 16;
	localparam int ADDR_W = 8;
	// timing
	localparam int CLOCK_MHZ = 250;
	localparam int SAMPLE_TIME_US = 125;
	localparam int SAMPLE_CYC = SAMPLE_TIME_US * CLOCK_MHZ;
	localparam int EXT_DET_TIME_US = 2000;
	localparam int EXT_DET_CYC = EXT_DET_TIME_US * CLOCK_MHZ;
	localparam int HS_HOLD_SAMPLES = 16;
	// restraint slope is a fraction of 2**SLOPE_SHIFT
	localparam int SLOPE_SHIFT = 6;
	// ct change symmetry tolerance, 1/(2**CT_TOL_SHIFT)
	localparam int CT_TOL_SHIFT = 3;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TERM_EN = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DISC_USE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_BRK_USE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PICKUP = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SLOPE = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_DELTA = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_CHK_SEL = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_CT_ALARM = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_COND = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_ZONE_MAP = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_CHECK_MAP = 8'h60;
	// field positions
	localparam int SLOPE_HIGH_POS = 8;
	localparam int STAT_EXT_POS = 8;
	localparam int STAT_CHK_POS = 16;
	localparam int COND_OPEN_POS = 16;
	// reset values
	localparam logic [15:0] PICKUP_RST = 16'h0100;
	localparam logic [7:0] SLOPE_NORM_RST = 8'h20;
	localparam logic [7:0] SLOPE_HIGH_RST = 8'h38;
	localparam logic [15:0] DELTA_RST = 16'h0200;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// disconnect closed unless contacts read no=0, nc=1
	function automatic logic bzs_disc_closed(input logic no, input logic nc);
		return no | ~nc;
	endfunction

	function automatic logic [31:0] bzs_mag(input logic signed [31:0] v);
		return (v < 0) ? 32'(-v) : 32'(v);
	endfunction

	// byte-lane merge of a register write
	function automatic logic [31:0] bzs_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction
endpackage

// file: bzs_diff_elem.sv
// one adaptive differential element with external-fault and ct supervision
`timescale 1ns/100ps
`default_nettype none
module bzs_diff_elem #(
	parameter int NT = bzs_pkg::NUM_TERM,
	parameter int W = bzs_pkg::CUR_W,
	parameter int EXT_WIN = bzs_pkg::EXT_DET_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic sample_en,
	input wire logic [NT*W-1:0] cur,
	input wire logic [NT-1:0] incl,
	input wire logic [15:0] pickup,
	input wire logic [7:0] slope_norm,
	input wire logic [7:0] slope_high,
	input wire logic [15:0] delta_min,
	output logic op,
	output logic ext_fault,
	output logic ct_event
);
	import bzs_pkg::*;
	localparam int SW = W + 8;

	typedef struct packed {
		logic [SW-1:0] opq;
		logic [SW-1:0] rsq;
		logic op;
		logic ext;
		logic ct;
		logic [31:0] win;
		logic [7:0] hold;
	} bzs_diff_state_t;
	bzs_diff_state_t s_reg, s_next;

	// sums, deltas and decision per sample
	always_comb begin
		logic signed [SW-1:0] acc;
		logic [SW-1:0] rs;
		logic [SW-1:0] oq;
		logic signed [SW:0] dr;
		logic signed [SW:0] dop;
		logic [SW-1:0] adr;
		logic [SW+7:0] lhs;
		logic [SW+7:0] rhs;
		acc = '0;
		rs = '0;
		lhs = '0;
		rhs = '0;
		s_next = s_reg;
		s_next.ct = 1'b0;
		for (int t = 0; t < NT; t++) begin
			if (incl[t]) begin
				acc = acc + SW'($signed(cur[t*W +: W]));
				rs = rs + SW'(bzs_mag(32'($signed(cur[t*W +: W]))));
			end
		end
		oq = SW'(bzs_mag(32'(acc)));
		dr = $signed({1'b0, rs}) - $signed({1'b0, s_reg.rsq});
		dop = $signed({1'b0, oq}) - $signed({1'b0, s_reg.opq});
		adr = SW'(bzs_mag(32'(dr)));
		// detection window is counted in clocks from the restraint onset
		if (s_reg.win != 32'h0) begin
			s_next.win = s_reg.win - 32'h1;
		end
		if (sample_en) begin
			s_next.rsq = rs;
			s_next.opq = oq;
			if (dr >= $signed({1'b0, SW'(delta_min)})) begin
				if (s_reg.win == 32'h0) begin
					s_next.win = 32'(EXT_WIN);
				end
				if (s_reg.win != 32'h0 || s_reg.ext) begin
					if ((dop <<< 2) < dr) begin
						s_next.ext = 1'b1;
						s_next.hold = 8'(HS_HOLD_SAMPLES);
					end
				end else if ((dop <<< 2) < dr) begin
					s_next.ext = 1'b1;
					s_next.hold = 8'(HS_HOLD_SAMPLES);
				end
			end else if (s_reg.hold != 8'h0) begin
				s_next.hold = s_reg.hold - 8'h1;
			end else begin
				s_next.ext = 1'b0;
			end
			// equal and opposite changes flag a failed ct
			if (adr >= SW'(delta_min) && (dr[SW] != dop[SW])
				&& SW'(bzs_mag(32'(dr + dop))) <= (adr >> CT_TOL_SHIFT)) begin
				s_next.ct = 1'b1;
			end
			// steeper slope while external fault is flagged
			lhs = (SW+8)'(oq) << SLOPE_SHIFT;
			rhs = (SW+8)'(rs) * (SW+8)'(s_next.ext ? slope_high : slope_norm);
			s_next.op = (oq > SW'(pickup)) && (lhs > rhs);
		end
		if (rst) begin
			s_next = '0;
		end
	end

	// state register
	always_ff @(posedge clock) begin
		s_reg <= s_next;
	end

	assign op = s_reg.op;
	assign ext_fault = s_reg.ext;
	assign ct_event = s_reg.ct;
endmodule
`default_nettype wire

// file: bzs_zone_select.sv
// zone selection, trip gating and register slave for the bus differential zones
// Summary of operation
// - each terminal's assignment condition is registered first, and only that result routes currents to zones.
// - a terminal whose condition is true adds its current to every zone that maps it.
// - a terminal whose condition goes false is dropped from the zone sums one clock later, once its registered condition updates.
// - trip outputs to a terminal are issued only while its condition is true.
// - a disconnect reads open only for normally-open 0 with normally-closed 1, closed otherwise.
// - the condition may include the breaker contact so an open breaker removes the current.
// - three check zones with their own differential elements watch their mapped terminals.
// - a check-zone output asserts on internal faults and stays low for external ones.
// - six zone differential elements decide within one sample, far under a power cycle.
// - an external fault is flagged within 2 ms when restraint rises much faster than operate.
// - a flagged external fault switches the element to its steeper restraint slope.
// - equal and opposite restraint and operate changes raise a ct alarm for the zone.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module bzs_zone_select #(
	parameter int NT = bzs_pkg::NUM_TERM,
	parameter int NZ = bzs_pkg::NUM_ZONE,
	parameter int NC = bzs_pkg::NUM_CHECK,
	parameter int W = bzs_pkg::CUR_W,
	parameter int SAMPLE_CYC = bzs_pkg::SAMPLE_CYC,
	parameter int EXT_WIN = bzs_pkg::EXT_DET_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [bzs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bzs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NT-1:0] aux_contact_normally_open,
	input wire logic [NT-1:0] aux_contact_normally_closed,
	input wire logic [NT-1:0] breaker_closed,
	input wire logic [NT*W-1:0] term_current,
	output logic [NT-1:0] term_trip,
	output logic [NZ-1:0] zone_trip,
	output logic [NC-1:0] check_op,
	output logic [NZ-1:0] ext_fault,
	output logic [NZ-1:0] ct_alarm
);
	import bzs_pkg::*;

	typedef struct packed {
		logic enable;
		logic [NT-1:0] term_en;
		logic [NT-1:0] disc_use;
		logic [NT-1:0] brk_use;
		logic [15:0] pickup;
		logic [7:0] slope_norm;
		logic [7:0] slope_high;
		logic [15:0] delta_min;
		logic [NZ-1:0][1:0] chk_sel;
		logic [NZ-1:0][NT-1:0] zone_map;
		logic [NC-1:0][NT-1:0] check_map;
		logic [NT-1:0] cond;
		logic [NT-1:0] disc_open;
		logic [31:0] div;
		logic tick;
		logic [NZ-1:0] zone_trip;
		logic [NZ-1:0] ext_fault;
		logic [NZ-1:0] ct_alarm;
		logic [NC-1:0] check_op;
		logic [NT-1:0] term_trip;
		logic awready;
		logic wready;
		logic aw_full;
		logic w_full;
		logic [ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bzs_state_t;
	bzs_state_t s_reg, s_next;

	logic [NZ-1:0] z_op;
	logic [NZ-1:0] z_ext;
	logic [NZ-1:0] z_ct;
	logic [NC-1:0] c_op;

	// zone elements see only terminals whose registered condition is true
	for (genvar z = 0; z < NZ; z++) begin : g_zone
		bzs_diff_elem #(.NT(NT), .W(W), .EXT_WIN(EXT_WIN)) u_elem (
			.clock(clock),
			.rst(rst),
			.sample_en(s_reg.tick),
			.cur(term_current),
			.incl(s_reg.zone_map[z] & s_reg.cond),
			.pickup(s_reg.pickup),
			.slope_norm(s_reg.slope_norm),
			.slope_high(s_reg.slope_high),
			.delta_min(s_reg.delta_min),
			.op(z_op[z]),
			.ext_fault(z_ext[z]),
			.ct_event(z_ct[z])
		);
	end

	// check zones ignore zone selection, so a wrong map cannot blind them
	for (genvar c = 0; c < NC; c++) begin : g_check
		bzs_diff_elem #(.NT(NT), .W(W), .EXT_WIN(EXT_WIN)) u_elem (
			.clock(clock),
			.rst(rst),
			.sample_en(s_reg.tick),
			.cur(term_current),
			.incl(s_reg.check_map[c]),
			.pickup(s_reg.pickup),
			.slope_norm(s_reg.slope_norm),
			.slope_high(s_reg.slope_high),
			.delta_min(s_reg.delta_min),
			.op(c_op[c]),
			.ext_fault(),
			.ct_event()
		);
	end

	// selection, trips, sample divider and register slave
	always_comb begin
		logic [31:0] rd;
		logic [1:0] rr;
		logic [31:0] wv;
		logic hit;
		logic [NT-1:0] closed;
		logic [NZ-1:0] zt;
		logic [NT-1:0] tt;
		rd = 32'h0;
		rr = RESP_OKAY;
		wv = 32'h0;
		hit = 1'b0;
		closed = '0;
		zt = '0;
		tt = '0;
		s_next = s_reg;

		// sample enable pulse
		s_next.tick = 1'b0;
		if (s_reg.div >= 32'(SAMPLE_CYC - 1)) begin
			s_next.div = 32'h0;
			s_next.tick = 1'b1;
		end else begin
			s_next.div = s_reg.div + 32'h1;
		end

		for (int t = 0; t < NT; t++) begin
			closed[t] = bzs_disc_closed(aux_contact_normally_open[t],
				aux_contact_normally_closed[t]);
		end
		s_next.disc_open = ~closed;
		s_next.cond = {NT{s_reg.enable}} & s_reg.term_en
			& (~s_reg.disc_use | closed) & (~s_reg.brk_use | breaker_closed);

		for (int z = 0; z < NZ; z++) begin
			// element, check zone and no ct alarm
			zt[z] = z_op[z] && 32'(s_reg.chk_sel[z]) < NC && c_op[s_reg.chk_sel[z]]
				&& !s_reg.ct_alarm[z];
			if (zt[z]) begin
				tt = tt | s_reg.zone_map[z];
			end
		end
		s_next.zone_trip = zt;
		// no trip to a deselected terminal
		s_next.term_trip = tt & s_reg.cond;
		s_next.check_op = c_op;
		s_next.ext_fault = z_ext;

		// write channels are taken in either order, answered when both are held
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_full = 1'b1;
			s_next.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_full = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
			s_next.bvalid = 1'b1;
			hit = 1'b1;
			case (s_reg.waddr)
				OFS_CTRL: begin
					wv = bzs_merge(32'(s_reg.enable), s_reg.wdata, s_reg.wstrb);
					s_next.enable = wv[0];
				end
				OFS_TERM_EN: begin
					wv = bzs_merge(32'(s_reg.term_en), s_reg.wdata, s_reg.wstrb);
					s_next.term_en = wv[NT-1:0];
				end
				OFS_DISC_USE: begin
					wv = bzs_merge(32'(s_reg.disc_use), s_reg.wdata, s_reg.wstrb);
					s_next.disc_use = wv[NT-1:0];
				end
				OFS_BRK_USE: begin
					wv = bzs_merge(32'(s_reg.brk_use), s_reg.wdata, s_reg.wstrb);
					s_next.brk_use = wv[NT-1:0];
				end
				OFS_PICKUP: begin
					wv = bzs_merge(32'(s_reg.pickup), s_reg.wdata, s_reg.wstrb);
					s_next.pickup = wv[15:0];
				end
				OFS_SLOPE: begin
					wv = bzs_merge({16'h0, s_reg.slope_high, s_reg.slope_norm},
						s_reg.wdata, s_reg.wstrb);
					s_next.slope_norm = wv[7:0];
					s_next.slope_high = wv[SLOPE_HIGH_POS +: 8];
				end
				OFS_DELTA: begin
					wv = bzs_merge(32'(s_reg.delta_min), s_reg.wdata, s_reg.wstrb);
					s_next.delta_min = wv[15:0];
				end
				OFS_CHK_SEL: begin
					wv = bzs_merge(32'(s_reg.chk_sel), s_reg.wdata, s_reg.wstrb);
					s_next.chk_sel = wv[2*NZ-1:0];
				end
				OFS_CT_ALARM: begin
					wv = bzs_merge(32'h0, s_reg.wdata, s_reg.wstrb);
					s_next.ct_alarm = s_reg.ct_alarm & ~wv[NZ-1:0];
				end
				OFS_STATUS, OFS_COND: begin
					hit = 1'b1;
				end
				default: begin
					hit = 1'b0;
					for (int z = 0; z < NZ; z++) begin
						if (s_reg.waddr == OFS_ZONE_MAP + ADDR_W'(4 * z)) begin
							wv = bzs_merge(32'(s_reg.zone_map[z]), s_reg.wdata, s_reg.wstrb);
							s_next.zone_map[z] = wv[NT-1:0];
							hit = 1'b1;
						end
					end
					for (int c = 0; c < NC; c++) begin
						if (s_reg.waddr == OFS_CHECK_MAP + ADDR_W'(4 * c)) begin
							wv = bzs_merge(32'(s_reg.check_map[c]), s_reg.wdata, s_reg.wstrb);
							s_next.check_map[c] = wv[NT-1:0];
							hit = 1'b1;
						end
					end
				end
			endcase
			s_next.bresp = hit ? RESP_OKAY : RESP_SLVERR;
		end
		// sticky alarm, a new event beats the clear
		s_next.ct_alarm = s_next.ct_alarm | z_ct;

		// read: one outstanding, data registered
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_reg.arready) begin
			case (s_axi_araddr)
				OFS_CTRL: rd = 32'(s_reg.enable);
				OFS_TERM_EN: rd = 32'(s_reg.term_en);
				OFS_DISC_USE: rd = 32'(s_reg.disc_use);
				OFS_BRK_USE: rd = 32'(s_reg.brk_use);
				OFS_PICKUP: rd = 32'(s_reg.pickup);
				OFS_SLOPE: rd = {16'h0, s_reg.slope_high, s_reg.slope_norm};
				OFS_DELTA: rd = 32'(s_reg.delta_min);
				OFS_CHK_SEL: rd = 32'(s_reg.chk_sel);
				OFS_CT_ALARM: rd = 32'(s_reg.ct_alarm);
				OFS_STATUS: begin
					rd = 32'(s_reg.zone_trip);
					rd[STAT_EXT_POS +: NZ] = s_reg.ext_fault;
					rd[STAT_CHK_POS +: NC] = s_reg.check_op;
				end
				OFS_COND: begin
					rd = 32'(s_reg.cond);
					rd[COND_OPEN_POS +: NT] = s_reg.disc_open;
				end
				default: begin
					rr = RESP_SLVERR;
					for (int z = 0; z < NZ; z++) begin
						if (s_axi_araddr == OFS_ZONE_MAP + ADDR_W'(4 * z)) begin
							rd = 32'(s_reg.zone_map[z]);
							rr = RESP_OKAY;
						end
					end
					for (int c = 0; c < NC; c++) begin
						if (s_axi_araddr == OFS_CHECK_MAP + ADDR_W'(4 * c)) begin
							rd = 32'(s_reg.check_map[c]);
							rr = RESP_OKAY;
						end
					end
				end
			endcase
			s_next.rvalid = 1'b1;
			s_next.rdata = rd;
			s_next.rresp = rr;
		end
		// readies are registered so every bus output is a flop
		s_next.awready = !s_next.aw_full && !s_next.bvalid;
		s_next.wready = !s_next.w_full && !s_next.bvalid;
		s_next.arready = !s_next.rvalid;

		if (rst) begin
			s_next = '0;
			s_next.pickup = PICKUP_RST;
			s_next.slope_norm = SLOPE_NORM_RST;
			s_next.slope_high = SLOPE_HIGH_RST;
			s_next.delta_min = DELTA_RST;
		end
	end

	// state register
	always_ff @(posedge clock) begin
		s_reg <= s_next;
	end

	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign term_trip = s_reg.term_trip;
	assign zone_trip = s_reg.zone_trip;
	assign check_op = s_reg.check_op;
	assign ext_fault = s_reg.ext_fault;
	assign ct_alarm = s_reg.ct_alarm;
endmodule
`default_nettype wire

// file: bzs_zone_select_chk.sv
// concurrent checks on the zone selection top-level ports
`timescale 1ns/100ps
`default_nettype none
module bzs_zone_select_chk
	import bzs_pkg::*;
#(
	parameter int NT = 7,
	parameter int NZ = 6,
	parameter int NC = 3
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bzs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NT-1:0] term_trip,
	input wire logic [NZ-1:0] zone_trip,
	input wire logic [NC-1:0] check_op,
	input wire logic [NZ-1:0] ext_fault,
	input wire logic [NZ-1:0] ct_alarm
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// bus answers stand until taken, arrive on time, one read at a time, unmapped reads fail
	chk_wresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped early");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
	chk_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
	chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h3C
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
	// protection gating
	chk_trip_needs_zone: assert property (|term_trip |-> |zone_trip)
		else $error("terminal trip without zone trip");
	chk_zone_needs_check: assert property (|zone_trip |-> |check_op || |$past(check_op))
		else $error("zone trip without check zone");
	chk_ct_blocks_trip: assert property (~|(ct_alarm & $past(ct_alarm)
		& $past(ct_alarm, 2) & zone_trip)) else $error("zone trip under ct alarm");
	chk_alarm_sticky: assert property (|($past(ct_alarm) & ~ct_alarm) |-> s_axi_bvalid
		|| $past(s_axi_bvalid)) else $error("ct alarm cleared without write");
	// main scenarios reached
	cov_zone_trip: cover property ($rose(|zone_trip));
	cov_ext_fault: cover property ($rose(|ext_fault));
	cov_ct_alarm: cover property ($rose(|ct_alarm));
	cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind bzs_zone_select bzs_zone_select_chk #(.NT(NT), .NZ(NZ), .NC(NC)) u_chk (.clock, .rst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .term_trip, .zone_trip, .check_op, .ext_fault, .ct_alarm);
`default_nettype wire

// file: bzs_field_model.sv
// disconnect, breaker and terminal current model for the zone selection bench
`timescale 1ns/100ps
`default_nettype none
module bzs_field_model #(
	parameter int NT = 7,
	parameter int W = 16,
	parameter int TRAVEL = 4
) (
	input wire logic clock,
	input wire logic [NT-1:0] disc_cmd,
	input wire logic [NT-1:0] brk_cmd,
	input wire logic raw_en,
	input wire logic [NT-1:0] raw_no,
	input wire logic [NT-1:0] raw_nc,
	input wire logic [NT*W-1:0] cur_cmd,
	output logic [NT-1:0] no_out,
	output logic [NT-1:0] nc_out,
	output logic [NT-1:0] brk_out,
	output logic [NT*W-1:0] cur_out
);
	logic [NT-1:0] pos [TRAVEL] = '{default: '1};
	// main contact lags the command by the travel time
	always @(posedge clock) begin
		pos[0] <= disc_cmd;
		for (int i = 1; i < TRAVEL; i++) begin
			pos[i] <= pos[i-1];
		end
	end
	// on closing the b contact leaves first and the a contact arrives last, on opening the reverse: both low mid-travel
	assign no_out = raw_en ? raw_no : (disc_cmd & pos[TRAVEL-1]);
	assign nc_out = raw_en ? raw_nc : (~disc_cmd & ~pos[TRAVEL-1]);
	assign brk_out = brk_cmd;
	assign cur_out = cur_cmd;
endmodule
`default_nettype wire

// file: test_bus_zone_selection_logic.sv
// self-checking bench for the zone selection block
`timescale 1ns/100ps
`default_nettype none
module test_bus_zone_selection_logic;
	import bzs_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] awaddr = 8'h00;
	logic [ADDR_W-1:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [6:0] disc_cmd = 7'h7F;
	logic [6:0] brk_cmd = 7'h7F;
	logic [6:0] raw_no = 7'h7F;
	logic [6:0] raw_nc = 7'h7F;
	logic raw_en = 1'b0;
	logic [111:0] cur = 112'h0;
	logic [6:0] c_no, c_nc, brk, term_trip;
	logic [111:0] tcur;
	logic [5:0] zone_trip, ext_fault, ct_alarm;
	logic [2:0] check_op;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	// short sample period and external-fault window keep the run brief
	bzs_zone_select #(.SAMPLE_CYC(8), .EXT_WIN(64)) dut (.clock(clock), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.aux_contact_normally_open(c_no), .aux_contact_normally_closed(c_nc),
		.breaker_closed(brk), .term_current(tcur), .term_trip(term_trip),
		.zone_trip(zone_trip), .check_op(check_op), .ext_fault(ext_fault), .ct_alarm(ct_alarm));
	bzs_field_model u_field (.clock(clock), .disc_cmd(disc_cmd), .brk_cmd(brk_cmd),
		.raw_en(raw_en), .raw_no(raw_no), .raw_nc(raw_nc), .cur_cmd(cur), .no_out(c_no),
		.nc_out(c_nc), .brk_out(brk), .cur_out(tcur));
	initial begin
		forever #2 clock = ~clock;
	end
	task automatic end_sim();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// hang guard, well above the fewer than a thousand cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(posedge clock);
			if (pa && awready) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clock); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
		// one idle edge so a following call never re-raises bready in the same step
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, ed);
		chk(32'(rresp), 32'(er));
		// one idle edge so a following call never re-raises rready in the same step
		@(posedge clock);
	endtask
	// terminal 0 and 1 currents, then several samples to settle
	task automatic setc(input int a0, input int a1);
		cur <= {80'h0, 16'(a1), 16'(a0)};
		wt(48);
	endtask
	task automatic outs(input logic [5:0] ez, input logic [6:0] et);
		chk(32'(zone_trip), 32'(ez));
		chk(32'(term_trip), 32'(et));
	endtask
	initial begin
		wt(20);
		rst <= 1'b0;
		wt(2);
		rd(OFS_PICKUP, 32'h0000_0100, RESP_OKAY);
		rd(OFS_SLOPE, 32'h0000_3820, RESP_OKAY);
		rd(OFS_DELTA, 32'h0000_0200, RESP_OKAY);
		rd(8'h3C, 32'h0, RESP_SLVERR);
		wr(8'h3C, 32'h1, RESP_SLVERR);
		wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		// zone 0 over terminals 0..2, check zone 0 over all; huge step masks detectors
		wr(OFS_DELTA, 32'h7FFF, RESP_OKAY);
		wr(OFS_TERM_EN, 32'h7F, RESP_OKAY);
		wr(OFS_DISC_USE, 32'h7F, RESP_OKAY);
		wr(OFS_ZONE_MAP, 32'h07, RESP_OKAY);
		wr(OFS_CHECK_MAP, 32'h7F, RESP_OKAY);
		wr(OFS_CHK_SEL, 32'hFFC, RESP_OKAY);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		raw_en <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			raw_no <= {6'h3F, k[1]};
			raw_nc <= {6'h3F, k[0]};
			wt(4);
			rd(OFS_COND, (k == 1) ? 32'h0001_007E : 32'h0000_007F, RESP_OKAY);
		end
		raw_en <= 1'b0;
		setc(1000, 1000);
		outs(6'h01, 7'h07);
		rd(OFS_STATUS, 32'h0001_0001, RESP_OKAY);
		wr(OFS_CHK_SEL, 32'hFFD, RESP_OKAY);
		wt(24);
		outs(6'h00, 7'h00);
		wr(OFS_CHK_SEL, 32'hFFC, RESP_OKAY);
		setc(1000, -1000);
		outs(6'h00, 7'h00);
		chk(32'(check_op), 32'h0);
		wr(OFS_CHECK_MAP, 32'h01, RESP_OKAY);
		wt(24);
		outs(6'h00, 7'h00);
		disc_cmd <= 7'h7D;
		wt(48);
		outs(6'h01, 7'h05);
		disc_cmd <= 7'h7F;
		brk_cmd <= 7'h7E;
		wr(OFS_BRK_USE, 32'h01, RESP_OKAY);
		wt(48);
		outs(6'h01, 7'h06);
		brk_cmd <= 7'h7F;
		wr(OFS_BRK_USE, 32'h0, RESP_OKAY);
		wr(OFS_CHECK_MAP, 32'h7F, RESP_OKAY);
		setc(0, 0);
		wr(OFS_DELTA, 32'h200, RESP_OKAY);
		wr(OFS_CT_ALARM, 32'h3F, RESP_OKAY);
		// through fault step, then an imbalance between the two slopes
		setc(3000, -3000);
		chk(32'(ext_fault), 32'h01);
		setc(4600, -1400);
		outs(6'h00, 7'h00);
		wt(150);
		chk(32'(ext_fault), 32'h0);
		outs(6'h01, 7'h07);
		// one terminal current vanishes as from an open ct
		setc(1000, -1000);
		setc(1000, 0);
		chk(32'(ct_alarm), 32'h01);
		outs(6'h00, 7'h00);
		rd(OFS_CT_ALARM, 32'h01, RESP_OKAY);
		wr(OFS_CT_ALARM, 32'h01, RESP_OKAY);
		wt(32);
		chk(32'(ct_alarm), 32'h0);
		outs(6'h01, 7'h07);
		end_sim();
	end
endmodule
`default_nettype wire
